// File: inc/usft_cfg.svh
/* Register map, field positions and reset values of the UART shadow/FIFO-test slice.
   Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word. */
`ifndef USFT_CFG_SVH
`define USFT_CFG_SVH
`define USFT_AW 8
`define USFT_OFF_DIV_LO 8'h20
`define USFT_OFF_DIV_HI 8'h24
`define USFT_OFF_WIN_LO 8'h30
`define USFT_OFF_WIN_HI 8'h6C
`define USFT_OFF_ACC 8'h70
`define USFT_OFF_PEEK 8'h74
`define USFT_OFF_INJ 8'h78
`define USFT_OFF_STAT 8'h7C
`define USFT_OFF_TXLVL 8'h80
`define USFT_OFF_RXLVL 8'h84
`define USFT_BIT_FE 9
`define USFT_BIT_PE 8
`define USFT_BIT_RXFULL 4
`define USFT_BIT_RXNE 3
`define USFT_BIT_TXEMPTY 2
`define USFT_BIT_TXNF 1
`define USFT_BIT_BUSY 0
`define USFT_RST_DIV 8'h00
`define USFT_RST_ACC 1'b0
`define USFT_RST_STAT 5'h06
`define USFT_LVL_W 5
`define USFT_RESP_OKAY 2'h0
`define USFT_RESP_SLVERR 2'h2
`endif

// File: inc/usft_pkg.sv
/* Types shared by the UART shadow/FIFO-test slice.
   Assumes usft_cfg.svh carries all numeric constants. */
package usft_pkg;
	typedef enum logic [3:0] {
		sel_none,
		sel_div_lo,
		sel_div_hi,
		sel_win,
		sel_acc,
		sel_peek,
		sel_inj,
		sel_stat,
		sel_txlvl,
		sel_rxlvl
	} usft_sel_t;
endpackage : usft_pkg

// File: src/usft_axil_wr.sv
/* AXI4-Lite write channel slave: takes address and data in either order,
   fires one write when both are held, answers on B. Assumes one write in flight. */
`timescale 1ns/1ps
`include "usft_cfg.svh"
module usft_axil_wr import usft_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [`USFT_AW-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [1:0] resp_i,
	output logic fire_o,
	output logic [`USFT_AW-1:0] addr_o,
	output logic [31:0] data_o,
	output logic [3:0] strb_o
);
	logic aw_held_ff;
	logic w_held_ff;
	logic nxt_aw_held;
	logic nxt_w_held;
	logic aw_hs;
	logic w_hs;

	assign aw_hs = awvalid_i && awready_o;
	assign w_hs = wvalid_i && wready_o;
	assign fire_o = aw_held_ff && w_held_ff && !bvalid_o;
	assign nxt_aw_held = (aw_held_ff || aw_hs) && !fire_o;
	assign nxt_w_held = (w_held_ff || w_hs) && !fire_o;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready_o <= 1'b0;
			wready_o <= 1'b0;
		end else if (ce_i) begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			awready_o <= !nxt_aw_held;
			wready_o <= !nxt_w_held;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			addr_o <= 8'h00;
			data_o <= 32'h0000_0000;
			strb_o <= 4'h0;
		end else if (ce_i) begin
			if (aw_hs) begin
				addr_o <= awaddr_i;
			end
			if (w_hs) begin
				data_o <= wdata_i;
				strb_o <= wstrb_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= `USFT_RESP_OKAY;
		end else if (ce_i) begin
			if (fire_o) begin
				bvalid_o <= 1'b1;
				bresp_o <= resp_i;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end
endmodule : usft_axil_wr

// File: src/usft_status.sv
/* Registered FIFO status flags derived from the FIFO levels and the busy line.
   Assumes levels and busy arrive synchronous to clk_i. */
`timescale 1ns/1ps
`include "usft_cfg.svh"
module usft_status import usft_pkg::*; #(
	parameter int FIFO_DEPTH = 16,
	parameter bit HAS_FIFO_STAT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [`USFT_LVL_W-1:0] tx_level_i,
	input wire logic [`USFT_LVL_W-1:0] rx_level_i,
	input wire logic busy_i,
	output logic [4:0] flags_o
);
	localparam logic [`USFT_LVL_W-1:0] LVL_FULL = `USFT_LVL_W'(FIFO_DEPTH);
	localparam logic [4:0] RST_FLAGS = `USFT_RST_STAT;
	logic [4:0] nxt_flags;
	logic [4:0] flag_ff;

	always_comb begin
		nxt_flags = 5'h00;
		nxt_flags[`USFT_BIT_RXFULL] = rx_level_i == LVL_FULL;
		nxt_flags[`USFT_BIT_RXNE] = rx_level_i != 5'h00;
		nxt_flags[`USFT_BIT_TXEMPTY] = tx_level_i == 5'h00;
		nxt_flags[`USFT_BIT_TXNF] = tx_level_i != LVL_FULL;
		nxt_flags[`USFT_BIT_BUSY] = busy_i;
	end

	for (genvar i = 0; i < 5; i++) begin : g_flag
		always_ff @(posedge clk_i) begin
			if (!rst_b_i) begin
				flag_ff[i] <= RST_FLAGS[i];
			end else if (ce_i) begin
				flag_ff[i] <= nxt_flags[i];
			end
		end
	end

	// FIFO flags only exist with the status option
	assign flags_o = HAS_FIFO_STAT ? flag_ff : {4'h0, flag_ff[`USFT_BIT_BUSY]};
endmodule : usft_status

// File: src/usft_top.sv
/* usft_top: UART register slice for the low-power divisor, shadow buffer windows,
   FIFO test access, FIFO status and levels, reached over AXI4-Lite.
   Assumes FIFOs, receive buffer, holding register and serial engine sit outside
   and present levels, head data and busy synchronously to clk_i. */
`timescale 1ns/1ps
`include "usft_cfg.svh"
module usft_top import usft_pkg::*; #(
	parameter bit HAS_LP_RX = 1'b1,
	parameter bit HAS_SHADOW = 1'b1,
	parameter bit HAS_FIFO_ACCESS = 1'b1,
	parameter bit HAS_FIFO_STAT = 1'b1,
	parameter bit HAS_FIFOS = 1'b1,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [`USFT_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [`USFT_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic line_control_dlab_i,
	input wire logic [7:0] rx_buf_data_i,
	input wire logic [7:0] tx_head_data_i,
	input wire logic [7:0] transmit_holding_data_i,
	input wire logic [`USFT_LVL_W-1:0] tx_level_i,
	input wire logic [`USFT_LVL_W-1:0] rx_level_i,
	input wire logic busy_i,
	output logic [15:0] lp_divisor_o,
	output logic th_load_o,
	output logic [7:0] th_wdata_o,
	output logic rx_buf_pop_o,
	output logic tx_fifo_pop_o,
	output logic rx_inject_o,
	output logic [9:0] rx_inject_word_o,
	output logic fifo_access_mode_o
);
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 31) begin : g_bad_depth
		$error("usft_top: FIFO_DEPTH must lie in 2..31");
	end

	localparam logic [`USFT_LVL_W-1:0] LVL_FULL = `USFT_LVL_W'(FIFO_DEPTH);

	logic wr_fire;
	logic [`USFT_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	usft_sel_t wr_sel;
	usft_sel_t rd_sel;
	logic [1:0] wr_resp;
	logic ar_hs;
	logic [31:0] rd_word;
	logic [4:0] stat_flags;
	logic [7:0] div_lo_ff;
	logic [7:0] div_hi_ff;

	// Shared address decode for the read and write paths
	function automatic usft_sel_t decode(input logic [`USFT_AW-1:0] a, input logic wr, input logic dlab);
		usft_sel_t s;
		s = sel_none;
		if (a[1:0] != 2'h0) begin
			s = sel_none;
		end else if (HAS_LP_RX && a == `USFT_OFF_DIV_LO) begin
			s = sel_div_lo;
		end else if (HAS_LP_RX && a == `USFT_OFF_DIV_HI) begin
			s = sel_div_hi;
		end else if (HAS_SHADOW && a >= `USFT_OFF_WIN_LO && a <= `USFT_OFF_WIN_HI && (wr || !dlab)) begin
			s = sel_win;
		end else if (a == `USFT_OFF_ACC) begin
			s = sel_acc;
		end else if (HAS_FIFO_ACCESS && !wr && a == `USFT_OFF_PEEK) begin
			s = sel_peek;
		end else if (HAS_FIFO_ACCESS && wr && a == `USFT_OFF_INJ) begin
			s = sel_inj;
		end else if (!wr && a == `USFT_OFF_STAT) begin
			s = sel_stat;
		end else if (HAS_FIFO_STAT && !wr && a == `USFT_OFF_TXLVL) begin
			s = sel_txlvl;
		end else if (HAS_FIFO_STAT && !wr && a == `USFT_OFF_RXLVL) begin
			s = sel_rxlvl;
		end
		return s;
	endfunction : decode

	usft_axil_wr u_wr (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.awaddr_i(s_axi_awaddr_i),
		.awvalid_i(s_axi_awvalid_i),
		.awready_o(s_axi_awready_o),
		.wdata_i(s_axi_wdata_i),
		.wstrb_i(s_axi_wstrb_i),
		.wvalid_i(s_axi_wvalid_i),
		.wready_o(s_axi_wready_o),
		.bresp_o(s_axi_bresp_o),
		.bvalid_o(s_axi_bvalid_o),
		.bready_i(s_axi_bready_i),
		.resp_i(wr_resp),
		.fire_o(wr_fire),
		.addr_o(wr_addr),
		.data_o(wr_data),
		.strb_o(wr_strb)
	);

	usft_status #(
		.FIFO_DEPTH(FIFO_DEPTH),
		.HAS_FIFO_STAT(HAS_FIFO_STAT)
	) u_stat (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.tx_level_i(tx_level_i),
		.rx_level_i(rx_level_i),
		.busy_i(busy_i),
		.flags_o(stat_flags)
	);

	assign wr_sel = decode(wr_addr, 1'b1, line_control_dlab_i);
	assign rd_sel = decode(s_axi_araddr_i, 1'b0, line_control_dlab_i);
	assign wr_resp = (wr_sel == sel_none) ? `USFT_RESP_SLVERR : `USFT_RESP_OKAY;
	assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
	assign lp_divisor_o = {div_hi_ff, div_lo_ff};

	// Divisor latch pair
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			div_lo_ff <= `USFT_RST_DIV;
			div_hi_ff <= `USFT_RST_DIV;
		end else if (ce_i && wr_fire && wr_strb[0]) begin
			if (wr_sel == sel_div_lo) begin
				div_lo_ff <= wr_data[7:0];
			end
			if (wr_sel == sel_div_hi) begin
				div_hi_ff <= wr_data[7:0];
			end
		end
	end

	// Test access mode enable
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			fifo_access_mode_o <= `USFT_RST_ACC;
		end else if (ce_i && HAS_FIFO_ACCESS && wr_fire && wr_sel == sel_acc && wr_strb[0]) begin
			fifo_access_mode_o <= wr_data[0];
		end
	end

	// Shadow transmit window into the holding path
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			th_load_o <= 1'b0;
			th_wdata_o <= 8'h00;
		end else if (ce_i) begin
			th_load_o <= wr_fire && wr_sel == sel_win && wr_strb[0];
			if (wr_fire && wr_sel == sel_win && wr_strb[0]) begin
				th_wdata_o <= wr_data[7:0];
			end
		end
	end

	// Receive injection with error flags
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rx_inject_o <= 1'b0;
			rx_inject_word_o <= 10'h000;
		end else if (ce_i) begin
			rx_inject_o <= wr_fire && wr_sel == sel_inj && fifo_access_mode_o && wr_strb[0];
			if (wr_fire && wr_sel == sel_inj) begin
				rx_inject_word_o[7:0] <= wr_data[7:0];
				rx_inject_word_o[9] <= wr_data[`USFT_BIT_FE] && wr_strb[1];
				rx_inject_word_o[8] <= wr_data[`USFT_BIT_PE] && wr_strb[1];
			end
		end
	end

	// Read data; fields narrower than a word leave the upper bits zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_sel)
			sel_div_lo: rd_word[7:0] = div_lo_ff;
			sel_div_hi: rd_word[7:0] = div_hi_ff;
			sel_win: rd_word[7:0] = rx_buf_data_i;
			sel_acc: rd_word[0] = fifo_access_mode_o;
			sel_peek: begin
				if (fifo_access_mode_o) begin
					rd_word[7:0] = HAS_FIFOS ? tx_head_data_i : transmit_holding_data_i;
				end
			end
			sel_stat: rd_word[4:0] = stat_flags;
			sel_txlvl: rd_word[4:0] = tx_level_i;
			sel_rxlvl: rd_word[4:0] = rx_level_i;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `USFT_RESP_OKAY;
		end else if (ce_i) begin
			if (ar_hs) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_word;
				s_axi_rresp_o <= (rd_sel == sel_none) ? `USFT_RESP_SLVERR : `USFT_RESP_OKAY;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end else if (!s_axi_rvalid_o) begin
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// Read side effects on the buffers
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rx_buf_pop_o <= 1'b0;
			tx_fifo_pop_o <= 1'b0;
		end else if (ce_i) begin
			rx_buf_pop_o <= ar_hs && rd_sel == sel_win;
			tx_fifo_pop_o <= ar_hs && rd_sel == sel_peek && fifo_access_mode_o && HAS_FIFOS
				&& tx_level_i != 5'h00;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	div_low_a: assert property (ce_i && wr_fire && wr_sel == sel_div_lo && wr_strb[0]
		|=> lp_divisor_o[7:0] == $past(wr_data[7:0]))
		else $error("divisor low byte not written");
	div_high_a: assert property (ce_i && wr_fire && wr_sel == sel_div_hi && wr_strb[0]
		|=> lp_divisor_o[15:8] == $past(wr_data[7:0]))
		else $error("divisor high byte not written");
	div_reset_a: assert property (disable iff (1'b0) (!rst_b_i || !HAS_LP_RX)
		|=> lp_divisor_o == 16'h0000)
		else $error("divisor not zero after reset or without option");
	win_mirror_a: assert property (ce_i && ar_hs && rd_sel == sel_win
		|=> s_axi_rvalid_o && s_axi_rdata_o == {24'h00_0000, $past(rx_buf_data_i)} && rx_buf_pop_o)
		else $error("shadow receive window returned wrong data");
	win_dlab_a: assert property (ce_i && ar_hs && line_control_dlab_i
		&& s_axi_araddr_i >= `USFT_OFF_WIN_LO && s_axi_araddr_i <= `USFT_OFF_WIN_HI
		|=> s_axi_rresp_o == `USFT_RESP_SLVERR && !rx_buf_pop_o)
		else $error("shadow receive window decoded with divisor access set");
	win_load_a: assert property (ce_i && wr_fire && wr_sel == sel_win && wr_strb[0]
		|=> th_load_o && th_wdata_o == $past(wr_data[7:0]) ##1 !th_load_o || !ce_i || wr_fire)
		else $error("shadow transmit window did not load holding path");
	acc_lock_a: assert property (!HAS_FIFO_ACCESS |-> !fifo_access_mode_o)
		else $error("access mode set without access option");
	peek_data_a: assert property (ce_i && ar_hs && rd_sel == sel_peek && fifo_access_mode_o
		|=> s_axi_rdata_o[7:0] == (HAS_FIFOS ? $past(tx_head_data_i) : $past(transmit_holding_data_i)))
		else $error("peek returned wrong byte");
	inj_push_a: assert property (ce_i && wr_fire && wr_sel == sel_inj && fifo_access_mode_o && wr_strb[0]
		|=> rx_inject_o && rx_inject_word_o[7:0] == $past(wr_data[7:0]))
		else $error("inject did not push data byte");
	inj_idle_a: assert property (rx_inject_o |-> $past(fifo_access_mode_o))
		else $error("inject pushed outside access mode");
	inj_frame_a: assert property (ce_i && wr_fire && wr_sel == sel_inj && &wr_strb[1:0]
		|=> rx_inject_word_o[9] == $past(wr_data[9]))
		else $error("framing error flag not stored");
	inj_parity_a: assert property (ce_i && wr_fire && wr_sel == sel_inj && &wr_strb[1:0]
		|=> rx_inject_word_o[8] == $past(wr_data[8]))
		else $error("parity error flag not stored");
	rx_full_a: assert property (ce_i && HAS_FIFO_STAT
		|=> stat_flags[`USFT_BIT_RXFULL] == ($past(rx_level_i) == LVL_FULL))
		else $error("receive full flag wrong");
	rx_ne_a: assert property (ce_i && HAS_FIFO_STAT
		|=> stat_flags[`USFT_BIT_RXNE] == ($past(rx_level_i) != 5'h00))
		else $error("receive not-empty flag wrong");
	tx_empty_a: assert property (ce_i && HAS_FIFO_STAT
		|=> stat_flags[`USFT_BIT_TXEMPTY] == ($past(tx_level_i) == 5'h00))
		else $error("transmit empty flag wrong");
	stat_reset_a: assert property (disable iff (1'b0) HAS_FIFO_STAT && !rst_b_i
		|=> stat_flags == `USFT_RST_STAT)
		else $error("status flags wrong after reset");
	tx_nf_a: assert property (ce_i && HAS_FIFO_STAT
		|=> stat_flags[`USFT_BIT_TXNF] == ($past(tx_level_i) != LVL_FULL))
		else $error("transmit not-full flag wrong");
	busy_a: assert property (ce_i |=> stat_flags[`USFT_BIT_BUSY] == $past(busy_i))
		else $error("busy flag does not follow engine");
	level_a: assert property (ce_i && ar_hs && rd_sel == sel_rxlvl
		|=> s_axi_rdata_o == {27'h000_0000, $past(rx_level_i)})
		else $error("receive level read wrong");
	reserved_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
		else $error("reserved read bits not zero");
	peek_pop_a: assert property (ce_i && ar_hs && rd_sel == sel_peek && fifo_access_mode_o
		&& HAS_FIFOS && tx_level_i != 5'h00 |=> tx_fifo_pop_o)
		else $error("peek did not pop transmit head");

	inject_c: cover property (wr_fire && wr_sel == sel_inj && fifo_access_mode_o);
	peek_c: cover property (ar_hs && rd_sel == sel_peek && fifo_access_mode_o);
	window_c: cover property (ar_hs && rd_sel == sel_win ##[1:8] wr_fire && wr_sel == sel_win);
	both_c: cover property (wr_fire && ar_hs);
endmodule : usft_top

// File: tb/usft_far_model.sv
/* Far-side model of the slice: transmit and receive FIFOs, holding register, busy line.
   Assumes the slice's pulses are one cycle wide and synchronous to clk_i. */
`timescale 1ns/1ps
module usft_far_model #(
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic th_load_i,
	input wire logic [7:0] th_wdata_i,
	input wire logic tx_pop_i,
	input wire logic rx_push_i,
	input wire logic [9:0] rx_word_i,
	input wire logic rx_pop_i,
	output logic [7:0] tx_head_o,
	output logic [7:0] hold_o,
	output logic [4:0] tx_level_o,
	output logic [4:0] rx_level_o,
	output logic [7:0] rx_head_o,
	output logic [9:0] rx_word_o,
	output logic busy_o
);
	logic [7:0] txq[$];
	logic [9:0] rxq[$];
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			txq.delete();
			rxq.delete();
			hold_o <= 8'h00;
		end else begin
			if (th_load_i) begin
				hold_o <= th_wdata_i;
				if (txq.size() < DEPTH)
					txq.push_back(th_wdata_i);
			end
			if (tx_pop_i && txq.size() != 0)
				void'(txq.pop_front());
			if (rx_push_i && rxq.size() < DEPTH)
				rxq.push_back(rx_word_i);
			if (rx_pop_i && rxq.size() != 0)
				void'(rxq.pop_front());
		end
		tx_level_o <= 5'(txq.size());
		rx_level_o <= 5'(rxq.size());
		// Empty FIFO inverts its head every cycle instead of holding it
		tx_head_o <= (txq.size() != 0) ? txq[0] : ~tx_head_o;
		rx_word_o <= (rxq.size() != 0) ? rxq[0] : ~rx_word_o;
		rx_head_o <= (rxq.size() != 0) ? rxq[0][7:0] : ~rx_head_o;
		busy_o <= txq.size() != 0;
	end
endmodule : usft_far_model

// File: tb/tb_top.sv
/* Self-checking bench for usft_top over AXI4-Lite, with the far-side FIFO model.
   Assumes the register map and codes of usft_cfg.svh. */
`timescale 1ns/1ps
`include "usft_cfg.svh"
module tb_top;
	import usft_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, dlab = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, th_load, rx_pop, tx_pop, rx_push, acc_mode, busy;
	logic [1:0] bresp, rresp;
	logic [7:0] rx_head, tx_head, hold, th_wdata;
	logic [4:0] tx_lvl, rx_lvl;
	logic [15:0] lp_div;
	logic [9:0] inj_word, rx_word;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	logic [31:0] d;
	logic [1:0] r;

	usft_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1),
		.line_control_dlab_i(dlab), .rx_buf_data_i(rx_head), .tx_head_data_i(tx_head),
		.transmit_holding_data_i(hold), .tx_level_i(tx_lvl), .rx_level_i(rx_lvl), .busy_i(busy),
		.lp_divisor_o(lp_div), .th_load_o(th_load), .th_wdata_o(th_wdata), .rx_buf_pop_o(rx_pop),
		.tx_fifo_pop_o(tx_pop), .rx_inject_o(rx_push), .rx_inject_word_o(inj_word),
		.fifo_access_mode_o(acc_mode));

	usft_far_model far_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .th_load_i(th_load), .th_wdata_i(th_wdata),
		.tx_pop_i(tx_pop), .rx_push_i(rx_push), .rx_word_i(inj_word), .rx_pop_i(rx_pop),
		.tx_head_o(tx_head), .hold_o(hold), .tx_level_o(tx_lvl), .rx_level_o(rx_lvl),
		.rx_head_o(rx_head), .rx_word_o(rx_word), .busy_o(busy));

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_t, w_t, b_t;
		@(posedge clk_i);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		forever begin
			@(negedge clk_i);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			resp = bresp;
			@(posedge clk_i);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
			if (b_t)
				break;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ar_t, r_t;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(negedge clk_i);
			ar_t = arvalid && arready;
			r_t = rvalid;
			v = rdata;
			resp = rresp;
			@(posedge clk_i);
			if (ar_t)
				arvalid <= 1'b0;
			if (r_t)
				break;
		end
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
		logic [31:0] v;
		logic [1:0] rs;
		rd(a, v, rs);
		chk(v, exp);
		chk({30'h0, rs}, {30'h0, exp_r});
	endtask : rd_chk

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test;
		end
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd_chk(`USFT_OFF_DIV_LO, 32'h0, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_DIV_HI, 32'h0, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_ACC, 32'h0, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_STAT, 32'h06, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_TXLVL, 32'h0, `USFT_RESP_OKAY);
		$display("test reset done");
		wr(`USFT_OFF_DIV_LO, 32'hFFFFFF5A, r);
		wr(`USFT_OFF_DIV_HI, 32'h123456A5, r);
		chk({16'h0, lp_div}, 32'h0000A55A);
		rd_chk(`USFT_OFF_DIV_LO, 32'h5A, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_DIV_HI, 32'hA5, `USFT_RESP_OKAY);
		$display("test divisor done");
		wr(`USFT_OFF_WIN_LO, 32'hFFFFFF11, r);
		chk({30'h0, r}, {30'h0, `USFT_RESP_OKAY});
		wr(`USFT_OFF_WIN_HI, 32'h00000022, r);
		rd_chk(`USFT_OFF_TXLVL, 32'h2, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_STAT, 32'h03, `USFT_RESP_OKAY);
		$display("test transmit window done");
		rd_chk(`USFT_OFF_PEEK, 32'h0, `USFT_RESP_OKAY);
		wr(`USFT_OFF_INJ, 32'h000003FF, r);
		rd_chk(`USFT_OFF_RXLVL, 32'h0, `USFT_RESP_OKAY);
		wr(`USFT_OFF_ACC, 32'hFFFFFFFF, r);
		chk({31'h0, acc_mode}, 32'h1);
		rd_chk(`USFT_OFF_ACC, 32'h1, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_PEEK, 32'h11, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_PEEK, 32'h22, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_TXLVL, 32'h0, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_STAT, 32'h06, `USFT_RESP_OKAY);
		$display("test peek done");
		for (int i = 0; i < 16; i++) begin
			wr(`USFT_OFF_INJ, {22'h3FFFFF, i[0], i[1], 8'h40 + 8'(i)}, r);
			if (i == 0)
				rd_chk(`USFT_OFF_STAT, 32'h0E, `USFT_RESP_OKAY);
		end
		rd_chk(`USFT_OFF_RXLVL, 32'h10, `USFT_RESP_OKAY);
		rd_chk(`USFT_OFF_STAT, 32'h1E, `USFT_RESP_OKAY);
		dlab <= 1'b1;
		rd_chk(`USFT_OFF_WIN_LO, 32'h0, `USFT_RESP_SLVERR);
		dlab <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			// Model head updates at the edge that ends the previous read
			@(negedge clk_i);
			chk({22'h0, rx_word}, {22'h0, i[0], i[1], 8'h40 + 8'(i)});
			rd_chk(8'(`USFT_OFF_WIN_LO + 4 * i), {24'h0, 8'h40 + 8'(i)}, `USFT_RESP_OKAY);
			if (i == 0)
				rd_chk(`USFT_OFF_STAT, 32'h0E, `USFT_RESP_OKAY);
		end
		rd_chk(`USFT_OFF_STAT, 32'h06, `USFT_RESP_OKAY);
		$display("test inject done");
		wr(8'hF0, 32'h1, r);
		chk({30'h0, r}, {30'h0, `USFT_RESP_SLVERR});
		wr(`USFT_OFF_STAT, 32'hFFFFFFFF, r);
		chk({30'h0, r}, {30'h0, `USFT_RESP_SLVERR});
		rd_chk(8'hF0, 32'h0, `USFT_RESP_SLVERR);
		$display("test refusals done");
		stop_test;
	end
endmodule : tb_top
